/* File: lrxd_pkg.sv */
// Constants and types shared by the receive datapath.
package lrxd_pkg;
  localparam int unsigned LRXD_PHASES     = 8;
  localparam int unsigned LRXD_WMAX       = 10;
  localparam int unsigned LRXD_SLIP_MAX   = 11;
  localparam int unsigned LRXD_SYNC_DEPTH = 6;
  localparam int unsigned LRXD_SYNC_PRIME = 3;
  localparam int unsigned LRXD_LOCK_RUNS  = 256;

  localparam logic [2:0] LRXD_HALF_TURN = 3'h4;
  localparam logic [2:0] LRXD_PHASE_RST = 3'h0;
  localparam logic [3:0] LRXD_W_DDR     = 4'h2;
  localparam logic [3:0] LRXD_W_SDR     = 4'h1;

  typedef enum logic [1:0] {
    LRXD_MODE_STATIC = 2'h0,
    LRXD_MODE_AUTO   = 2'h1,
    LRXD_MODE_SOFT   = 2'h2
  } lrxd_mode_t;

  typedef enum logic [1:0] {
    LRXD_PATH_DESER = 2'h0,
    LRXD_PATH_DDR   = 2'h1,
    LRXD_PATH_SDR   = 2'h2
  } lrxd_path_t;

  typedef enum logic [1:0] {
    LRXD_ST_TRAIN  = 2'h1,
    LRXD_ST_LOCKED = 2'h2
  } lrxd_align_st_t;
endpackage

/* File: lrxd_sync_fifo.sv */
// One-bit wide elastic synchronizer between aligner phase and high-speed read side.
`timescale 1ns/1ps
module lrxd_sync_fifo
  import lrxd_pkg::*;
#(
  parameter int unsigned DEPTH = LRXD_SYNC_DEPTH,
  parameter int unsigned PRIME = LRXD_SYNC_PRIME
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic clear,
  input  wire logic wr_data,
  output logic      rd_data,
  output logic      rd_valid
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW-1:0] FILL = AW'(PRIME);

  logic [DEPTH-1:0] mem_q;
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    fill_q;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == LAST) ? '0 : p + 1'b1;
  endfunction

  // Writes every bit; reads start once the buffer is primed half full.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mem_q    <= '0;
      wr_q     <= '0;
      rd_q     <= '0;
      fill_q   <= '0;
      rd_data  <= 1'b0;
      rd_valid <= 1'b0;
    end else if (clear) begin
      wr_q     <= '0;
      rd_q     <= '0;
      fill_q   <= '0;
      rd_valid <= 1'b0;
    end else begin
      mem_q[wr_q] <= wr_data;
      wr_q        <= wrap_inc(wr_q);
      if (fill_q == FILL) begin
        rd_data  <= mem_q[rd_q];
        rd_q     <= wrap_inc(rd_q);
        rd_valid <= 1'b1;
      end else begin
        fill_q   <= fill_q + 1'b1;
        rd_valid <= 1'b0;
      end
    end
  end
endmodule

/* File: lrxd_receiver.sv */
// Receive datapath: phase aligner, synchronizer, bit slip, deserializer and bypass.
//
// Contract
// R1: Deserializer shifts serial bits and loads words of 4, 6, 7, 8 or 10.
// R2: Deserializer can be bypassed for double-rate or single-rate capture.
// R3: Double-rate bypass registers and yields 2 bits; single-rate yields 1 bit.
// R4: Phase aligner and bit slip stay usable while the deserializer is bypassed.
// R5: Static mode uses a configured sampling phase, no automatic choice.
// R6: Static mode samples on configured rising or falling high-speed clock edge.
// R7: Static mode clocks bit slip and deserializer from the high-speed clock.
// R8: Automatic mode picks the best sampling phase to cancel skew.
// R9: Automatic mode writes synchronizer on aligned phase, reads on high-speed clock.
// R10: Soft recovery mode keeps stepping phase to follow transmitter frequency offset.
// R11: Soft recovery mode clocks bit slip and deserializer from aligned phase.
// R12: Soft recovery forwards aligned phase divided by word width; words follow it.
// R13: Soft recovery also forwards the generated parallel clock.
// R14: Parallel output is at most 10 bits wide.
// R15: Synchronizer is 1 bit by 6 deep, reset when aligner first locks.
// R16: Each realign rising edge adds one bit latency; holding gives no more.
// R17: Aligner chooses among eight equally spaced phases, 45 degree steps.
// R18: Bit slip rolls over at a configured 1 to 11 bit-times.
// R19: One word per configured bit count, first-received bit at a fixed place.
`timescale 1ns/1ps
module lrxd_receiver
  import lrxd_pkg::*;
#(
  parameter int unsigned WMAX      = LRXD_WMAX,
  parameter int unsigned LOCK_RUNS = LRXD_LOCK_RUNS
) (
  input  wire logic                   clock,
  input  wire logic                   rstn,
  input  wire logic [1:0]             mode,
  input  wire logic [1:0]             path,
  input  wire logic [3:0]             word_width,
  input  wire logic [3:0]             rollover_point,
  input  wire logic [2:0]             static_phase,
  input  wire logic                   static_fall_edge,
  input  wire logic [LRXD_PHASES-1:0] phase_samples,
  input  wire logic                   aligner_hold,
  input  wire logic                   aligner_reset,
  input  wire logic                   sync_reset,
  input  wire logic                   realign_req,
  output logic [WMAX-1:0]             rx_word,
  output logic                        rx_word_valid,
  output logic                        div_fwd_clock,
  output logic                        par_clock,
  output logic                        aligner_locked,
  output logic [2:0]                  aligned_phase,
  output logic                        slip_max
);
  localparam logic [8:0] LOCK_LAST = 9'(LOCK_RUNS - 1);

  lrxd_align_st_t   st_q;
  logic [8:0]       run_q;
  logic             clr_q;
  logic             pin_bit_q;
  logic             pin_valid_q;
  logic             fifo_bit;
  logic             fifo_valid;
  logic             sbit;
  logic             svalid;
  logic [LRXD_SLIP_MAX-1:0] hist_q;
  logic [3:0]       slip_q;
  logic             req_prev_q;
  logic             slipped;
  logic [WMAX-1:0]  shift_q;
  logic [3:0]       cnt_q;
  logic [3:0]       pcnt_q;
  logic [3:0]       eff_w;
  logic             par_tick;
  logic             has_edge;
  logic [2:0]       target;

  // Word width after bypass selection; narrow bypass paths override the factor.
  function automatic logic [3:0] width_of(input logic [1:0] p, input logic [3:0] w);
    case (p)
      LRXD_PATH_DDR: width_of = LRXD_W_DDR;
      LRXD_PATH_SDR: width_of = LRXD_W_SDR;
      default:       width_of = w;
    endcase
  endfunction

  function automatic logic [WMAX-1:0] mask_of(input logic [3:0] w);
    mask_of = WMAX'((1 << w) - 1);
  endfunction

  assign eff_w = width_of(path, word_width); // R2 R3 R14

  // Sampling target sits half a bit away from the first data transition found in the scan.
  // Adjacent phases inside the bit are scanned first; the wrap pair of the last and
  // first phase only counts when the edge sits at phase zero, else it would hide skew.
  always_comb begin
    has_edge = 1'b0;
    target   = aligned_phase;
    for (int i = 1; i <= LRXD_PHASES; i++) begin
      if (!has_edge && phase_samples[i % LRXD_PHASES] != phase_samples[i - 1]) begin
        has_edge = 1'b1;
        target   = 3'(i) + LRXD_HALF_TURN; // R8 R17
      end
    end
  end

  // Phase selection and lock tracking.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      aligned_phase <= LRXD_PHASE_RST;
      st_q          <= LRXD_ST_TRAIN;
      run_q         <= '0;
      clr_q         <= 1'b0;
    end else begin
      clr_q <= 1'b0;
      case (mode)
        LRXD_MODE_STATIC: begin
          aligned_phase <= static_phase + (static_fall_edge ? LRXD_HALF_TURN : 3'h0); // R5 R6
          st_q          <= LRXD_ST_TRAIN;
          run_q         <= '0;
        end
        default: begin
          if (aligner_reset) begin
            st_q  <= LRXD_ST_TRAIN;
            run_q <= '0;
          end else if (!aligner_hold && has_edge && target != aligned_phase) begin
            // One 45 degree step per bit, in the shorter direction.
            aligned_phase <= (3'(target - aligned_phase) < LRXD_HALF_TURN)
                             ? aligned_phase + 3'h1 : aligned_phase - 3'h1; // R8 R10 R17
            run_q <= '0;
            if (mode == LRXD_MODE_AUTO) begin
              st_q <= LRXD_ST_TRAIN;
            end
          end else if (has_edge && st_q == LRXD_ST_TRAIN) begin
            run_q <= run_q + 1'b1;
            if (run_q == LOCK_LAST) begin
              st_q  <= LRXD_ST_LOCKED;
              clr_q <= 1'b1; // R15
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      aligner_locked <= 1'b0;
    end else begin
      aligner_locked <= (st_q == LRXD_ST_LOCKED);
    end
  end

  // Pin register element captures the bit at the selected phase.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_bit_q   <= 1'b0;
      pin_valid_q <= 1'b0;
    end else begin
      pin_bit_q   <= phase_samples[aligned_phase]; // R3 R6
      pin_valid_q <= 1'b1;
    end
  end

  lrxd_sync_fifo #(
    .DEPTH (LRXD_SYNC_DEPTH),
    .PRIME (LRXD_SYNC_PRIME)
  ) u_sync (
    .clock    (clock),
    .rstn     (rstn),
    .clear    (clr_q | sync_reset),
    .wr_data  (pin_bit_q),
    .rd_data  (fifo_bit),
    .rd_valid (fifo_valid)
  ); // R15

  // Only automatic mode passes through the synchronizer; the other modes
  // feed bit slip directly from the pin register.
  assign sbit   = (mode == LRXD_MODE_AUTO) ? fifo_bit : pin_bit_q;     // R9 R7 R11
  assign svalid = (mode == LRXD_MODE_AUTO) ? fifo_valid : pin_valid_q; // R9

  assign slipped  = (slip_q == 4'h0) ? sbit : hist_q[slip_q - 4'h1];
  assign par_tick = svalid && (cnt_q == eff_w - 4'h1);

  // Bit slip: each accepted request lengthens the delay by one bit-time; the one reaching rollover_point clears it to zero.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hist_q     <= '0;
      slip_q     <= '0;
      req_prev_q <= 1'b0;
      slip_max   <= 1'b0;
    end else begin
      if (svalid) begin
        hist_q <= {hist_q[LRXD_SLIP_MAX-2:0], sbit}; // R4
      end
      if (par_tick) begin
        req_prev_q <= realign_req;
        slip_max   <= 1'b0;
        if (realign_req && !req_prev_q) begin // R16
          if (slip_q + 4'h1 >= rollover_point) begin
            slip_q   <= '0;
            slip_max <= 1'b1; // R18
          end else begin
            slip_q <= slip_q + 4'h1; // R16
          end
        end
      end
    end
  end

  // Deserializer: first-received bit lands at bit eff_w-1 of the word.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shift_q       <= '0;
      cnt_q         <= '0;
      rx_word       <= '0;
      rx_word_valid <= 1'b0;
    end else begin
      rx_word_valid <= 1'b0;
      if (svalid) begin
        shift_q <= {shift_q[WMAX-2:0], slipped}; // R1
        if (par_tick) begin
          cnt_q         <= '0;
          rx_word       <= {shift_q[WMAX-2:0], slipped} & mask_of(eff_w); // R19 R14
          rx_word_valid <= 1'b1; // R1 R12
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end

  // Forwarded clocks: divided recovered clock and free-running parallel clock.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pcnt_q        <= '0;
      par_clock     <= 1'b0;
      div_fwd_clock <= 1'b0;
    end else begin
      pcnt_q        <= (pcnt_q >= eff_w - 4'h1) ? 4'h0 : pcnt_q + 4'h1;
      par_clock     <= (pcnt_q < (eff_w >> 1)); // R13
      div_fwd_clock <= (cnt_q < (eff_w >> 1));  // R12
    end
  end
endmodule

/* File: lrxd_receiver_chk.sv */
// Port assertions for the receive datapath.
`timescale 1ns/1ps
module lrxd_receiver_chk
  import lrxd_pkg::*;
#(
  parameter int unsigned WMAX = LRXD_WMAX
) (
  input wire logic            clock,
  input wire logic            rstn,
  input wire logic [1:0]      mode,
  input wire logic [1:0]      path,
  input wire logic [2:0]      static_phase,
  input wire logic            static_fall_edge,
  input wire logic            aligner_hold,
  input wire logic            aligner_reset,
  input wire logic [WMAX-1:0] rx_word,
  input wire logic            rx_word_valid,
  input wire logic            div_fwd_clock,
  input wire logic            aligner_locked,
  input wire logic [2:0]      aligned_phase,
  input wire logic            slip_max
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_valid_one_cycle: assert property (path != LRXD_PATH_SDR && $stable(path) && rx_word_valid
    |=> !rx_word_valid) else $error("word valid longer than one cycle");
  a_word_holds: assert property (!rx_word_valid |-> $stable(rx_word))
    else $error("word changed without valid");
  a_ddr_two_bits: assert property (path == LRXD_PATH_DDR && rx_word_valid
    |-> rx_word[WMAX-1:2] == '0) else $error("double-rate word too wide");
  a_sdr_one_bit: assert property (path == LRXD_PATH_SDR && rx_word_valid
    |-> rx_word[WMAX-1:1] == '0) else $error("single-rate word too wide");
  a_static_phase_fixed: assert property (mode == LRXD_MODE_STATIC && $past(rstn) && $stable(mode)
    && $stable(static_phase) && $stable(static_fall_edge)
    |-> aligned_phase == static_phase + (static_fall_edge ? 3'h4 : 3'h0))
    else $error("static phase not as configured");
  a_phase_single_step: assert property (mode != LRXD_MODE_STATIC && $past(mode) != LRXD_MODE_STATIC
    && $past(rstn) && !$past(aligner_reset) |-> aligned_phase == $past(aligned_phase)
    || aligned_phase == $past(aligned_phase) + 3'h1 || aligned_phase == $past(aligned_phase) - 3'h1)
    else $error("aligner jumped more than one phase");
  a_hold_freezes: assert property ($past(aligner_hold) && $past(rstn) && mode != LRXD_MODE_STATIC
    && $past(mode) != LRXD_MODE_STATIC && !$past(aligner_reset) |-> $stable(aligned_phase))
    else $error("aligner moved while held");
  a_reset_unlocks: assert property (aligner_reset |-> ##2 !aligner_locked)
    else $error("lock kept through aligner reset");
  c_locked: cover property ($rose(aligner_locked));
  c_rollover: cover property ($rose(slip_max));
  c_div_clock: cover property ($rose(div_fwd_clock));
endmodule

/* File: lrxd_tx_model.sv */
// Upstream transmitter: repeats one word first bit first, later phases see the new bit.
`timescale 1ns/1ps
module lrxd_tx_model (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic [9:0] word,
  input  wire logic [3:0] width,
  input  wire logic [2:0] skew,
  output logic [7:0]      phase_samples
);
  logic [3:0] idx_q;
  logic       prev_q;
  logic       cur;
  assign cur = word[width - 4'h1 - idx_q];
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      idx_q  <= #1 4'h0;
      prev_q <= #1 1'b0;
    end else begin
      prev_q <= #1 cur;
      idx_q  <= #1 (idx_q + 4'h1 >= width) ? 4'h0 : idx_q + 4'h1;
    end
  end
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      phase_samples[p] = (p < skew) ? prev_q : cur;
    end
  end
endmodule

/* File: lrxd_receiver_tb.sv */
// Self-checking bench for the receive datapath.
`timescale 1ns/1ps
module lrxd_receiver_tb;
  import lrxd_pkg::*;
  logic clock = 0, rstn = 0, static_fall_edge = 0, aligner_hold = 0, aligner_reset = 0;
  logic sync_reset = 0, realign_req = 0, rx_word_valid, div_fwd_clock, par_clock;
  logic aligner_locked, slip_max, sm_seen;
  logic [1:0] mode = 0, path = 0;
  logic [3:0] word_width = 4, rollover_point = 4;
  logic [2:0] static_phase = 0, skew = 0, aligned_phase;
  logic [7:0] phase_samples;
  logic [9:0] word = 0, rx_word;
  logic [1:0] pt [7] = '{0, 0, 0, 0, 0, 1, 2};
  logic [3:0] wt [7] = '{4, 6, 7, 8, 10, 2, 1};
  int errors = 0, total_checks = 0, n, d, p;
  lrxd_receiver #(.LOCK_RUNS(8)) lrxd_receiver_i (.clock, .rstn, .mode, .path, .word_width,
    .rollover_point, .static_phase, .static_fall_edge, .phase_samples, .aligner_hold,
    .aligner_reset, .sync_reset, .realign_req, .rx_word, .rx_word_valid, .div_fwd_clock,
    .par_clock, .aligner_locked, .aligned_phase, .slip_max);
  lrxd_tx_model lrxd_tx_model_i (.clock, .rstn, .word, .width(word_width), .skew,
    .phase_samples);
  initial forever #10 clock = ~clock;
  always @(posedge clock) if (slip_max === 1'b1) sm_seen = 1'b1;
  task automatic end_of_test();
    if (errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    total_checks++;
    if (c !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic next_word();
    n = 0;
    while (rx_word_valid !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    if (n == 40) begin
      chk(1'b0, "no word");
      end_of_test();
    end
    cyc(1);
  endtask
  task automatic restart(input logic [1:0] m, pth, input logic [3:0] w, input logic [9:0] pat);
    mode = m;
    path = pth;
    word_width = w;
    word = pat;
    rstn = 1'b0;
    cyc(5);
    rstn = 1'b1;
    sm_seen = 1'b0;
  endtask
  initial begin
    cyc(1);
    for (int i = 0; i < 7; i++) begin
      restart(LRXD_MODE_STATIC, pt[i], wt[i], 10'h2D9);
      repeat (3) next_word();
      chk(rx_word === (10'h2D9 & ((10'h1 << wt[i]) - 10'h1)), "word mismatch");
    end
    static_fall_edge = 1'b1;
    static_phase = 3'h2;
    restart(LRXD_MODE_STATIC, LRXD_PATH_DESER, 4'h4, 10'h009);
    for (int k = 1; k < 5; k++) begin
      realign_req = 1'b1;
      repeat (2) next_word();
      realign_req = 1'b0;
      repeat (3) next_word();
      chk(rx_word === 10'(4'(8'h99 >> k)), "slip result");
    end
    chk(sm_seen, "no rollover flag");
    static_fall_edge = 1'b0;
    skew = 3'h3;
    restart(LRXD_MODE_AUTO, LRXD_PATH_DESER, 4'h4, 10'h005);
    aligner_hold = 1'b1;
    cyc(3);
    aligner_hold = 1'b0;
    for (d = 0; aligner_locked !== 1'b1 && d < 300; d++) cyc(1);
    chk(aligner_locked, "no lock");
    if (aligner_locked !== 1'b1) end_of_test();
    chk(aligned_phase === 3'h7, "auto phase");
    sync_reset = 1'b1;
    cyc(1);
    sync_reset = 1'b0;
    repeat (4) next_word();
    chk(rx_word === 10'h005 || rx_word === 10'h00A, "auto word");
    aligner_reset = 1'b1;
    cyc(1);
    aligner_reset = 1'b0;
    cyc(1);
    chk(!aligner_locked, "lock after reset");
    restart(LRXD_MODE_SOFT, LRXD_PATH_DESER, 4'h6, 10'h015);
    cyc(40);
    chk(aligned_phase === 3'h7, "soft phase");
    d = 0;
    p = 0;
    repeat (72) begin
      sm_seen = div_fwd_clock;
      n = par_clock;
      cyc(1);
      d += int'(div_fwd_clock && !sm_seen);
      p += int'(par_clock && n == 0);
    end
    chk(d == 12, "divided clock rate");
    chk(p == 12, "parallel clock rate");
    end_of_test();
  end
endmodule
bind lrxd_receiver lrxd_receiver_chk #(.WMAX(WMAX)) lrxd_receiver_chk_i (.clock(clock),
  .rstn(rstn), .mode(mode), .path(path), .static_phase(static_phase),
  .static_fall_edge(static_fall_edge), .aligner_hold(aligner_hold),
  .aligner_reset(aligner_reset), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
  .div_fwd_clock(div_fwd_clock), .aligner_locked(aligner_locked),
  .aligned_phase(aligned_phase), .slip_max(slip_max));
